//--- rtl/tafrp_pkg.sv
`default_nettype none
package tafrp_pkg;
    // widths of the table pointer and the row geometry
    localparam int PTR_W = 22;
    localparam int ROW_W = 16;
    localparam int COL_W = 6;
    localparam int HOLD_DEPTH = 64;

    // register byte offsets on the AHB-Lite bus
    localparam logic [7:0] REG_PTR_LOW = 8'h00;
    localparam logic [7:0] REG_PTR_HIGH = 8'h04;
    localparam logic [7:0] REG_PTR_UPPER = 8'h08;
    localparam logic [7:0] REG_LATCH = 8'h0C;
    localparam logic [7:0] REG_CTRL = 8'h10;
    localparam logic [7:0] REG_UNLOCK = 8'h14;
    localparam logic [7:0] REG_TBLOP = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;

    // memory_control_reg bit positions
    localparam int CTL_PROG_SEL = 7;
    localparam int CTL_CFG_SEL = 6;
    localparam int CTL_ROW_ERASE = 4;
    localparam int CTL_ABORT = 3;
    localparam int CTL_WRITE_ALLOW = 2;
    localparam int CTL_WRITE_START = 1;

    // table operation command and status bit positions
    localparam int OP_IS_WRITE = 2;
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 1;

    // unlock keys and the erased holding register value
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] HOLD_RESET = 8'hFF;

    // long write time
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned LONG_WRITE_TIME_US = 2000;
    localparam int unsigned LONG_WRITE_CYCLES_DEF = LONG_WRITE_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        TP_KEEP,
        TP_POST_INC,
        TP_POST_DEC,
        TP_PRE_INC
    } tafrp_ptr_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } tafrp_bus_req_t;
endpackage : tafrp_pkg
`default_nettype wire

//--- rtl/tafrp_hold_mem.sv
`timescale 1ns/1ps
`default_nettype none
module tafrp_hold_mem
    import tafrp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [COL_W-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic clr_all,
    input wire logic [COL_W-1:0] rd_idx,
    output logic [7:0] rd_data
);
    logic [7:0] mem [HOLD_DEPTH];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < HOLD_DEPTH; i++) begin
                mem[i] <= HOLD_RESET;
            end
        end else if (clr_all) begin
            for (int i = 0; i < HOLD_DEPTH; i++) begin
                mem[i] <= HOLD_RESET;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= HOLD_RESET;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_HOLD_STORE: assert property (wr_en && !clr_all |=> mem[$past(wr_idx)] == $past(wr_data))
        else $error("holding register did not take the table latch byte");
    AST_HOLD_CLEAR: assert property (clr_all |=> mem[0] == HOLD_RESET && mem[HOLD_DEPTH-1] == HOLD_RESET)
        else $error("holding registers not returned to all ones");
endmodule : tafrp_hold_mem
`default_nettype wire

//--- rtl/tafrp_flash_seq.sv
// How it works
// - pointer is upper, high, low bytes joined
// - low 21 bits address program bytes
// - top pointer bit selects configuration space
// - keep, post-inc, post-dec, pre-inc pointer modes
// - pointer steps touch only low 21 bits
// - table read fetches byte at full pointer
// - table write fills holding register by bits 5:0
// - program row chosen by pointer bits 21:6
// - erase row by bits 21:6, low ignored
// - address bit 0 picks word high/low byte
// - erase clears exactly one 64-byte row
// - 55h then AAh then start bit
// - processor stalls until the timer ends
// - programming covers one whole row only
// - 64 holding registers, short writes only
// - holding registers FFh on reset and after program
// - start bit set by software, cleared by hardware
// - completion sets sticky write done flag
// - reset mid-cycle or bad attempt sets abort
// - erase select cleared when erase completes
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tafrp_flash_seq
    import tafrp_pkg::*;
#(
    parameter int unsigned LONG_WRITE_CYCLES = LONG_WRITE_CYCLES_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic flash_rd_en,
    output logic [19:0] flash_word_addr,
    output logic flash_cfg_space,
    input wire logic [15:0] flash_rdata,
    output logic flash_prog_en,
    output logic flash_erase_en,
    output logic [ROW_W-1:0] flash_row,
    output logic [COL_W-1:0] flash_col,
    output logic [7:0] flash_wdata,
    output logic cpu_stall
);
    typedef enum logic [1:0] {LK_IDLE, LK_GOT_FIRST, LK_ARMED} tafrp_lock_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RD_ISSUE, ST_RD_CAPT, ST_STREAM, ST_TIMED} tafrp_state_t;

    tafrp_bus_req_t req;
    tafrp_lock_t lock_state;
    tafrp_state_t state;
    logic [PTR_W-1:0] table_pointer;
    logic [7:0] table_latch;
    logic program_space_select;
    logic config_space_select;
    logic row_erase_select;
    logic write_allow;
    logic write_start;
    logic write_abort_flag;
    logic write_done_flag;
    logic op_erase;
    logic rd_byte_sel;
    logic [23:0] timer;
    logic [COL_W-1:0] stream_idx;
    logic stream_issue;
    logic stream_vld_d;
    logic [COL_W-1:0] stream_col_d;
    logic [7:0] hold_rd_data;

    logic accept;
    logic wr_go;
    logic [7:0] wdat;
    logic op_go;
    logic start_req;
    logic start_ok;
    logic start_bad;
    logic cycle_end;
    tafrp_ptr_mode_t op_mode;
    logic [20:0] ptr_inc;
    logic [20:0] ptr_dec;
    logic [PTR_W-1:0] eff_addr;
    logic [PTR_W-1:0] next_pointer;

    assign accept = hsel && hready && htrans[1];
    assign wr_go = req.valid && req.write && hreadyout;
    assign wdat = hwdata[7:0];
    assign op_go = wr_go && req.addr == REG_TBLOP && state == ST_IDLE;
    assign op_mode = tafrp_ptr_mode_t'(hwdata[1:0]);
    assign start_req = wr_go && req.addr == REG_CTRL && wdat[CTL_WRITE_START] && state == ST_IDLE;
    assign start_ok = start_req && lock_state == LK_ARMED && wdat[CTL_WRITE_ALLOW]
        && wdat[CTL_PROG_SEL] && !wdat[CTL_CFG_SEL];
    assign start_bad = start_req && !start_ok;
    assign cycle_end = state == ST_TIMED && timer == 24'(LONG_WRITE_CYCLES - 1);

    // pointer arithmetic wraps within the low 21 bits only
    assign ptr_inc = table_pointer[20:0] + 21'h000001;
    assign ptr_dec = table_pointer[20:0] - 21'h000001;

    always_comb begin
        eff_addr = table_pointer;
        next_pointer = table_pointer;
        unique case (op_mode)
            TP_KEEP: next_pointer = table_pointer;
            TP_POST_INC: next_pointer = {table_pointer[21], ptr_inc};
            TP_POST_DEC: next_pointer = {table_pointer[21], ptr_dec};
            TP_PRE_INC: begin
                eff_addr = {table_pointer[21], ptr_inc};
                next_pointer = {table_pointer[21], ptr_inc};
            end
        endcase
    end

    // AHB-Lite address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hreadyout) begin
            req <= '{valid: accept, write: hwrite, addr: haddr[7:0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else if (accept && !hwrite) begin
            hrdata <= 32'h00000000;
            unique case (haddr[7:0])
                REG_PTR_LOW: hrdata[7:0] <= table_pointer[7:0];
                REG_PTR_HIGH: hrdata[7:0] <= table_pointer[15:8];
                REG_PTR_UPPER: hrdata[5:0] <= table_pointer[21:16];
                REG_LATCH: hrdata[7:0] <= table_latch;
                REG_CTRL: hrdata[7:0] <= {program_space_select, config_space_select, 1'b0,
                    row_erase_select, write_abort_flag, write_allow, write_start, 1'b0};
                REG_STATUS: hrdata[1:0] <= {cpu_stall, write_done_flag};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // unlock sequence; any other bus write drops it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_state <= LK_IDLE;
        end else if (wr_go) begin
            if (req.addr == REG_UNLOCK && wdat == KEY_FIRST) begin
                lock_state <= LK_GOT_FIRST;
            end else if (req.addr == REG_UNLOCK && wdat == KEY_SECOND
                && lock_state == LK_GOT_FIRST) begin
                lock_state <= LK_ARMED;
            end else begin
                lock_state <= LK_IDLE;
            end
        end
    end

    // table pointer bytes and pointer steps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            table_pointer <= 22'h000000;
        end else if (op_go) begin
            table_pointer <= next_pointer;
        end else if (wr_go && state == ST_IDLE) begin
            if (req.addr == REG_PTR_LOW) begin
                table_pointer[7:0] <= wdat;
            end
            if (req.addr == REG_PTR_HIGH) begin
                table_pointer[15:8] <= wdat;
            end
            if (req.addr == REG_PTR_UPPER) begin
                table_pointer[21:16] <= wdat[5:0];
            end
        end
    end

    // table latch: software writes it, table reads fill it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            table_latch <= 8'h00;
        end else if (state == ST_RD_CAPT) begin
            table_latch <= rd_byte_sel ? flash_rdata[15:8] : flash_rdata[7:0];
        end else if (wr_go && req.addr == REG_LATCH) begin
            table_latch <= wdat;
        end
    end

    // space selects and abort flag live on power-on reset so they survive a device reset
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            program_space_select <= 1'b0;
            config_space_select <= 1'b0;
            write_abort_flag <= 1'b0;
        end else begin
            if (wr_go && req.addr == REG_CTRL && state == ST_IDLE) begin
                program_space_select <= wdat[CTL_PROG_SEL];
                config_space_select <= wdat[CTL_CFG_SEL];
            end
            if (start_ok || start_bad) begin
                write_abort_flag <= 1'b1;
            end else if (cycle_end) begin
                write_abort_flag <= 1'b0;
            end else if (wr_go && req.addr == REG_CTRL) begin
                write_abort_flag <= wdat[CTL_ABORT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_allow <= 1'b0;
            row_erase_select <= 1'b0;
        end else if (cycle_end && op_erase) begin
            row_erase_select <= 1'b0;
        end else if (wr_go && req.addr == REG_CTRL && state == ST_IDLE) begin
            write_allow <= wdat[CTL_WRITE_ALLOW];
            row_erase_select <= wdat[CTL_ROW_ERASE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_start <= 1'b0;
            write_done_flag <= 1'b0;
        end else begin
            if (start_ok) begin
                write_start <= 1'b1;
            end else if (cycle_end) begin
                write_start <= 1'b0;
            end
            if (cycle_end) begin
                write_done_flag <= 1'b1;
            end else if (wr_go && req.addr == REG_STATUS && wdat[STAT_DONE]) begin
                write_done_flag <= 1'b0;
            end
        end
    end

    // sequencer: table reads, row streaming and the long write timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            hreadyout <= 1'b1;
            cpu_stall <= 1'b0;
            flash_rd_en <= 1'b0;
            flash_word_addr <= 20'h00000;
            flash_cfg_space <= 1'b0;
            flash_erase_en <= 1'b0;
            flash_row <= 16'h0000;
            rd_byte_sel <= 1'b0;
            op_erase <= 1'b0;
            timer <= 24'h000000;
            stream_idx <= 6'h00;
            stream_issue <= 1'b0;
        end else begin
            flash_rd_en <= 1'b0;
            flash_erase_en <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (op_go && !hwdata[OP_IS_WRITE]) begin
                        flash_rd_en <= 1'b1;
                        flash_word_addr <= eff_addr[20:1];
                        flash_cfg_space <= eff_addr[21];
                        rd_byte_sel <= eff_addr[0];
                        hreadyout <= 1'b0;
                        state <= ST_RD_ISSUE;
                    end else if (start_ok) begin
                        cpu_stall <= 1'b1;
                        flash_row <= table_pointer[21:6];
                        flash_cfg_space <= 1'b0;
                        op_erase <= wdat[CTL_ROW_ERASE];
                        timer <= 24'h000000;
                        if (wdat[CTL_ROW_ERASE]) begin
                            flash_erase_en <= 1'b1;
                            state <= ST_TIMED;
                        end else begin
                            stream_idx <= 6'h00;
                            stream_issue <= 1'b1;
                            state <= ST_STREAM;
                        end
                    end
                end
                ST_RD_ISSUE: state <= ST_RD_CAPT;
                ST_RD_CAPT: begin
                    hreadyout <= 1'b1;
                    state <= ST_IDLE;
                end
                ST_STREAM: begin
                    if (stream_issue) begin
                        stream_idx <= stream_idx + 6'h01;
                        if (stream_idx == 6'(HOLD_DEPTH - 1)) begin
                            stream_issue <= 1'b0;
                        end
                    end
                    if (stream_vld_d && stream_col_d == 6'(HOLD_DEPTH - 1)) begin
                        state <= ST_TIMED;
                    end
                end
                ST_TIMED: begin
                    timer <= timer + 24'h000001;
                    if (cycle_end) begin
                        cpu_stall <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // holding register bytes go out one per cycle; all-ones bytes are not strobed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stream_vld_d <= 1'b0;
            stream_col_d <= 6'h00;
            flash_prog_en <= 1'b0;
            flash_col <= 6'h00;
            flash_wdata <= HOLD_RESET;
        end else begin
            stream_vld_d <= state == ST_STREAM && stream_issue;
            stream_col_d <= stream_idx;
            flash_prog_en <= stream_vld_d && hold_rd_data != HOLD_RESET;
            flash_col <= stream_col_d;
            flash_wdata <= hold_rd_data;
        end
    end

    tafrp_hold_mem u_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(op_go && hwdata[OP_IS_WRITE]),
        .wr_idx(eff_addr[5:0]),
        .wr_data(table_latch),
        .clr_all(cycle_end && !op_erase),
        .rd_idx(stream_idx),
        .rd_data(hold_rd_data)
    );

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PTR_MSB_KEPT: assert property (op_go |=> table_pointer[21] == $past(table_pointer[21]))
        else $error("pointer step changed the top pointer bit");
    AST_POST_INC: assert property (op_go && op_mode == TP_POST_INC
        |=> table_pointer[20:0] == $past(table_pointer[20:0]) + 21'h000001)
        else $error("post increment did not advance the pointer");
    AST_READ_BYTE: assert property (state == ST_RD_CAPT
        |=> table_latch == ($past(rd_byte_sel) ? $past(flash_rdata[15:8])
        : $past(flash_rdata[7:0])))
        else $error("table read latched the wrong byte");
    AST_READ_ADDR: assert property (op_go && !hwdata[OP_IS_WRITE]
        |=> flash_rd_en && flash_cfg_space == $past(eff_addr[21])
        && flash_word_addr == $past(eff_addr[20:1]) ##2 hreadyout)
        else $error("table read not issued at the pointer");
    AST_START_UNLOCKED: assert property ($rose(cpu_stall) |-> $past(lock_state) == LK_ARMED)
        else $error("long write started without unlock sequence");
    AST_STALL_HOLDS: assert property ((start_ok || cpu_stall) && !cycle_end
        |=> cpu_stall && write_start)
        else $error("stall or start bit dropped before the timer");
    AST_CYCLE_END: assert property (cycle_end
        |=> !cpu_stall && !write_start && write_done_flag && !write_abort_flag)
        else $error("completion did not clear start and set done");
    AST_ERASE_SEL_CLR: assert property (cycle_end && op_erase |=> !row_erase_select)
        else $error("row erase select not cleared after erase");
    AST_BAD_ABORT: assert property (start_bad |=> write_abort_flag && !cpu_stall)
        else $error("improper start not flagged");
    AST_NO_FF_STROBE: assert property (flash_prog_en |-> flash_wdata != HOLD_RESET)
        else $error("all ones byte was strobed to the array");
    AST_ERASE_ROW: assert property (flash_erase_en |-> flash_row == $past(table_pointer[21:6]))
        else $error("erase row not taken from pointer bits 21:6");
    AST_DONE_STICKY: assert property (write_done_flag && !(wr_go && req.addr == REG_STATUS)
        |=> write_done_flag)
        else $error("write done flag cleared without software");
endmodule : tafrp_flash_seq
`default_nettype wire

//--- tb/tafrp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module tafrp_flash_model
    import tafrp_pkg::*;
(
    input wire logic hclk,
    input wire logic flash_rd_en,
    input wire logic [19:0] flash_word_addr,
    input wire logic flash_cfg_space,
    output logic [15:0] flash_rdata,
    input wire logic flash_prog_en,
    input wire logic flash_erase_en,
    input wire logic [ROW_W-1:0] flash_row,
    input wire logic [COL_W-1:0] flash_col,
    input wire logic [7:0] flash_wdata
);
    logic [7:0] mem [0:8191];
    logic [1:0] hold;
    logic [7:0] wl;
    assign wl = {flash_word_addr[6:0], 1'b0};
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5A;
        flash_rdata = 16'hA5A5;
        hold = 2'h0;
    end
    always @(posedge hclk) begin
        // a row erase sets all 64 bytes of the row
        if (flash_erase_en) for (int i = 0; i < 64; i++) mem[{flash_row[6:0], i[5:0]}] = 8'hFF;
        // programming only clears bits
        if (flash_prog_en) mem[{flash_row[6:0], flash_col}] &= flash_wdata;
        if (flash_rd_en) begin
            flash_rdata <= flash_cfg_space ? {(wl | 8'h01) ^ 8'hC3, wl ^ 8'hC3} :
                {mem[{flash_word_addr[11:0], 1'b1}], mem[{flash_word_addr[11:0], 1'b0}]};
            hold <= 2'h2;
        end else if (hold != 2'h0) hold <= hold - 2'h1;
        else flash_rdata <= ~flash_rdata;
    end
endmodule : tafrp_flash_model
`default_nettype wire

//--- tb/table_access_flash_row_programmer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module table_access_flash_row_programmer_tb import tafrp_pkg::*;;
    logic hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, rd_en, cfg, prog_en, erase_en, cpu_stall;
    logic [19:0] waddr;
    logic [15:0] rdata;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [7:0] wdata, lat;
    logic [31:0] r;
    logic [21:0] np;
    int fail_count = 0, checks_done = 0, prog_n, erase_n, n;
    logic [7:0] p_col, p_dat;
    logic [15:0] p_row, e_row;
    tafrp_flash_seq #(.LONG_WRITE_CYCLES(16)) dut (.hclk(hclk), .hresetn(hresetn),
        .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .flash_rd_en(rd_en), .flash_word_addr(waddr),
        .flash_cfg_space(cfg), .flash_rdata(rdata), .flash_prog_en(prog_en),
        .flash_erase_en(erase_en), .flash_row(row), .flash_col(col),
        .flash_wdata(wdata), .cpu_stall(cpu_stall));
    tafrp_flash_model fm (.hclk(hclk), .flash_rd_en(rd_en), .flash_word_addr(waddr),
        .flash_cfg_space(cfg), .flash_rdata(rdata), .flash_prog_en(prog_en),
        .flash_erase_en(erase_en), .flash_row(row), .flash_col(col), .flash_wdata(wdata));
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        if (prog_en === 1'b1) begin
            prog_n++;
            p_col = {2'h0, col};
            p_dat = wdata;
            p_row = row;
        end
        if (erase_en === 1'b1) begin
            erase_n++;
            e_row = row;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
            fail_count++;
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic set_ptr(input logic [21:0] p);
        wr(REG_PTR_UPPER, {2'h0, p[21:16]});
        wr(REG_PTR_HIGH, p[15:8]);
        wr(REG_PTR_LOW, p[7:0]);
    endtask : set_ptr
    task automatic tread(input logic [21:0] p, input logic [1:0] m);
        set_ptr(p);
        wr(REG_TBLOP, {6'h0, m});
        xfer(1'b0, REG_LATCH, 8'h0);
        lat = r[7:0];
        xfer(1'b0, REG_PTR_LOW, 8'h0);
        np[7:0] = r[7:0];
        xfer(1'b0, REG_PTR_HIGH, 8'h0);
        np[15:8] = r[7:0];
        xfer(1'b0, REG_PTR_UPPER, 8'h0);
        np[21:16] = r[5:0];
    endtask : tread
    task automatic start_long(input logic [7:0] ctl, input logic mid);
        wr(REG_CTRL, ctl & 8'hFD);
        wr(REG_UNLOCK, KEY_FIRST);
        if (mid) wr(REG_PTR_LOW, 8'h00);
        wr(REG_UNLOCK, KEY_SECOND);
        prog_n = 0;
        erase_n = 0;
        wr(REG_CTRL, ctl);
        #1;
        n = 0;
        while (cpu_stall === 1'b1 && n < 1000) begin
            @(posedge hclk);
            n++;
        end
        xfer(1'b0, REG_CTRL, 8'h0);
    endtask : start_long
    task automatic t_modes();
        logic [21:0] m_rd [4] = '{22'h10, 22'h10, 22'h10, 22'h11};
        logic [21:0] m_nx [4] = '{22'h10, 22'h11, 22'h0F, 22'h11};
        for (int i = 0; i < 4; i++) begin
            tread(22'h10, i[1:0]);
            chk(lat, m_rd[i][7:0] ^ 8'h5A);
            chk(np, m_nx[i]);
        end
        tread(22'h3FFFFF, 2'h1);
        chk(lat, 8'hFF ^ 8'hC3);
        chk(np, 22'h200000);
    endtask : t_modes
    task automatic t_refuse();
        logic [7:0] c [4] = '{8'h86, 8'h82, 8'hC6, 8'h06};
        for (int i = 0; i < 4; i++) begin
            start_long(c[i], i == 0);
            chk(n, 0);
            chk(r[3], 1'b1);
            chk(prog_n + erase_n, 0);
        end
    endtask : t_refuse
    task automatic t_program();
        set_ptr(22'h1C5);
        wr(REG_LATCH, 8'h0F);
        wr(REG_TBLOP, 8'h04);
        set_ptr(22'h1C6);
        wr(REG_LATCH, 8'hFF);
        wr(REG_TBLOP, 8'h04);
        set_ptr(22'h1C0);
        start_long(8'h86, 1'b0);
        chk(n >= 16, 1'b1);
        chk({r[3], r[1]}, 2'h0);
        chk({prog_n, p_col, p_dat, p_row}, {32'h1, 8'h05, 8'h0F, 16'h0007});
        xfer(1'b0, REG_STATUS, 8'h0);
        chk(r[STAT_DONE], 1'b1);
        tread(22'h1C5, 2'h0);
        chk(lat, 8'h0F);
        start_long(8'h86, 1'b0);
        chk(prog_n, 0);
        wr(REG_STATUS, 8'h01);
        xfer(1'b0, REG_STATUS, 8'h0);
        chk(r[STAT_DONE], 1'b0);
    endtask : t_program
    task automatic t_erase();
        set_ptr(22'h1E5);
        start_long(8'h96, 1'b0);
        chk({erase_n, e_row}, {32'h1, 16'h0007});
        chk(r[4], 1'b0);
        tread(22'h1C4, 2'h0);
        chk(lat, 8'hFF);
        tread(22'h1FF, 2'h0);
        chk(lat, 8'hFF);
        tread(22'h200, 2'h0);
        chk(lat, 8'h5A);
    endtask : t_erase
    task automatic t_reset_mid();
        set_ptr(22'h1C0);
        wr(REG_CTRL, 8'h84);
        wr(REG_UNLOCK, KEY_FIRST);
        wr(REG_UNLOCK, KEY_SECOND);
        wr(REG_CTRL, 8'h86);
        repeat (3) @(posedge hclk);
        chk(cpu_stall, 1'b1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, REG_CTRL, 8'h0);
        chk(r[7:0] & 8'hC8, 8'h88);
    endtask : t_reset_mid
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge hclk);
        chk({hreadyout, hresp, cpu_stall}, 3'h4);
        t_modes();
        t_refuse();
        t_program();
        t_erase();
        t_reset_mid();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        end_of_test();
    end
endmodule : table_access_flash_row_programmer_tb
`default_nettype wire
